//--- hw/ssms_pkg.sv
package ssms_pkg;
  // ==========================================
  // register byte addresses
  localparam logic [4:0] ADDR_RXCTL = 5'h00;
  localparam logic [4:0] ADDR_RXBUF = 5'h04;
  localparam logic [4:0] ADDR_TXCTL = 5'h08;
  localparam logic [4:0] ADDR_BAUD = 5'h0c;
  localparam logic [4:0] ADDR_BRGH = 5'h10;
  localparam logic [4:0] ADDR_BRGL = 5'h14;
  localparam logic [4:0] ADDR_TXBUF = 5'h18;
  localparam logic [4:0] ADDR_IRQ = 5'h1c;
  // ==========================================
  // field positions
  localparam int RX_SERIAL_PORT_ENABLE = 7;
  localparam int RX_RX9 = 6;
  localparam int RX_SINGLE_RX_ENABLE = 5;
  localparam int RX_CONTINUOUS_RX_ENABLE = 4;
  localparam int RX_OERR = 1;
  localparam int RX_RX9D = 0;
  localparam int TX_CLOCK_SOURCE_SELECT = 7;
  localparam int TX_TX9 = 6;
  localparam int TX_TRANSMIT_ENABLE = 5;
  localparam int TX_SHIFT_REGISTER_EMPTY = 1;
  localparam int TX_TX_NINTH_BIT_VALUE = 0;
  localparam int BD_DTP = 5;
  localparam int BD_CKP = 4;
  localparam int BD_WIDE = 3;
  localparam int IQ_RXDONE = 0;
  localparam int IQ_TXEMPTY = 1;
  localparam int IQ_RXIE = 2;
  localparam int IQ_TXIE = 3;
  // ==========================================
  // word lengths, last bit index
  localparam logic [3:0] LAST8 = 4'h7;
  localparam logic [3:0] LAST9 = 4'h8;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ==========================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TX = 2'b01,
    ST_RX = 2'b10
  } ssms_state_t;
  typedef struct packed {
    logic serial_port_enable;
    logic rx9;
    logic single_rx_enable;
    logic continuous_rx_enable;
    logic clock_source_select;
    logic tx9;
    logic transmit_enable;
    logic tx_ninth_bit_value;
    logic dtp;
    logic ckp;
    logic wide;
    logic rxIe;
    logic txIe;
  } ssms_cfg_t;
endpackage

//--- hw/ssms_sync_serial.sv
// Implementation choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ssms_sync_serial (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic coreSleep,
  input wire logic shiftClockIn,
  output logic shiftClockOut,
  output logic shiftClockOe_n,
  input wire logic shiftDataIn,
  output logic shiftDataOut,
  output logic shiftDataOe_n,
  output logic irqReq,
  output logic wakeCore
);
  // ==========================================
  // declarations
  ssms_pkg::ssms_cfg_t cfg_r;
  ssms_pkg::ssms_state_t state_r;
  logic [7:0] brgH_r;
  logic [7:0] brgL_r;
  logic [7:0] txBuf_r;
  logic txFull_r;
  logic txEmpty_r;
  logic [7:0] rxBuf_r;
  logic rx9d_r;
  logic rxDone_r;
  logic oerr_r;
  logic [8:0] shift_r;
  logic [3:0] bitCnt_r;
  logic [15:0] brgCnt_r;
  logic sclk_r;
  logic [2:0] ckSync_r;
  logic [2:0] dtSync_r;
  logic ckF_r;
  logic dtF_r;
  logic pinLvlPrev_r;
  logic [31:0] rdData_r;
  logic waitReq_r;
  logic acc;
  logic wrAcc;
  logic rdAcc;
  logic txWr;
  logic rxRd;
  logic txLoad;
  logic rxStart;
  logic busy;
  logic brgTick;
  logic fallEv;
  logic pinLvl;
  logic din;
  logic [3:0] lastBit;
  logic rxWordEv;
  logic srenClr;
  logic [15:0] divisor;
  logic [8:0] rxWord;
  logic [7:0] rdMux;

  // ==========================================
  // avalon slave: one wait cycle per access
  assign acc = (avs_read | avs_write) & ~waitReq_r;
  assign wrAcc = avs_write & acc & avs_byteenable[0];
  assign rdAcc = avs_read & acc;
  assign txWr = wrAcc && avs_address == ssms_pkg::ADDR_TXBUF;
  assign rxRd = rdAcc && avs_address == ssms_pkg::ADDR_RXBUF;

  always_comb
  begin
    rdMux = ssms_pkg::RST_BYTE;
    unique case (avs_address)
      ssms_pkg::ADDR_RXCTL:
      begin
        rdMux[ssms_pkg::RX_SERIAL_PORT_ENABLE] = cfg_r.serial_port_enable;
        rdMux[ssms_pkg::RX_RX9] = cfg_r.rx9;
        rdMux[ssms_pkg::RX_SINGLE_RX_ENABLE] = cfg_r.single_rx_enable;
        rdMux[ssms_pkg::RX_CONTINUOUS_RX_ENABLE] = cfg_r.continuous_rx_enable;
        rdMux[ssms_pkg::RX_OERR] = oerr_r;
        rdMux[ssms_pkg::RX_RX9D] = rx9d_r;
      end
      ssms_pkg::ADDR_RXBUF: rdMux = rxBuf_r;
      ssms_pkg::ADDR_TXCTL:
      begin
        rdMux[ssms_pkg::TX_CLOCK_SOURCE_SELECT] = cfg_r.clock_source_select;
        rdMux[ssms_pkg::TX_TX9] = cfg_r.tx9;
        rdMux[ssms_pkg::TX_TRANSMIT_ENABLE] = cfg_r.transmit_enable;
        rdMux[ssms_pkg::TX_SHIFT_REGISTER_EMPTY] = state_r != ssms_pkg::ST_TX;
        rdMux[ssms_pkg::TX_TX_NINTH_BIT_VALUE] = cfg_r.tx_ninth_bit_value;
      end
      ssms_pkg::ADDR_BAUD:
      begin
        rdMux[ssms_pkg::BD_DTP] = cfg_r.dtp;
        rdMux[ssms_pkg::BD_CKP] = cfg_r.ckp;
        rdMux[ssms_pkg::BD_WIDE] = cfg_r.wide;
      end
      ssms_pkg::ADDR_BRGH: rdMux = brgH_r;
      ssms_pkg::ADDR_BRGL: rdMux = brgL_r;
      ssms_pkg::ADDR_TXBUF: rdMux = txBuf_r;
      ssms_pkg::ADDR_IRQ:
      begin
        rdMux[ssms_pkg::IQ_RXDONE] = rxDone_r;
        rdMux[ssms_pkg::IQ_TXEMPTY] = txEmpty_r;
        rdMux[ssms_pkg::IQ_RXIE] = cfg_r.rxIe;
        rdMux[ssms_pkg::IQ_TXIE] = cfg_r.txIe;
      end
      default: rdMux = ssms_pkg::RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waitReq_r <= 1'b1;
      rdData_r <= 32'h0000_0000;
    end
    else if ((avs_read | avs_write) && waitReq_r)
    begin
      waitReq_r <= 1'b0;
      rdData_r <= avs_read ? {24'h00_0000, rdMux} : 32'h0000_0000;
    end
    else
      waitReq_r <= 1'b1;
  end

  // ==========================================
  // configuration registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_r <= '0;
      brgH_r <= ssms_pkg::RST_BYTE;
      brgL_r <= ssms_pkg::RST_BYTE;
    end
    else if (wrAcc)
    begin
      unique case (avs_address)
        ssms_pkg::ADDR_RXCTL:
        begin
          cfg_r.serial_port_enable <= avs_writedata[ssms_pkg::RX_SERIAL_PORT_ENABLE];
          cfg_r.rx9 <= avs_writedata[ssms_pkg::RX_RX9];
          cfg_r.single_rx_enable <= avs_writedata[ssms_pkg::RX_SINGLE_RX_ENABLE];
          cfg_r.continuous_rx_enable <= avs_writedata[ssms_pkg::RX_CONTINUOUS_RX_ENABLE];
        end
        ssms_pkg::ADDR_TXCTL:
        begin
          cfg_r.clock_source_select <= avs_writedata[ssms_pkg::TX_CLOCK_SOURCE_SELECT];
          cfg_r.tx9 <= avs_writedata[ssms_pkg::TX_TX9];
          cfg_r.transmit_enable <= avs_writedata[ssms_pkg::TX_TRANSMIT_ENABLE];
          cfg_r.tx_ninth_bit_value <= avs_writedata[ssms_pkg::TX_TX_NINTH_BIT_VALUE];
        end
        ssms_pkg::ADDR_BAUD:
        begin
          cfg_r.dtp <= avs_writedata[ssms_pkg::BD_DTP];
          cfg_r.ckp <= avs_writedata[ssms_pkg::BD_CKP];
          cfg_r.wide <= avs_writedata[ssms_pkg::BD_WIDE];
        end
        ssms_pkg::ADDR_BRGH: brgH_r <= avs_writedata[7:0];
        ssms_pkg::ADDR_BRGL: brgL_r <= avs_writedata[7:0];
        ssms_pkg::ADDR_IRQ:
        begin
          cfg_r.rxIe <= avs_writedata[ssms_pkg::IQ_RXIE];
          cfg_r.txIe <= avs_writedata[ssms_pkg::IQ_TXIE];
        end
        default:
        begin
        end
      endcase
      // a write elsewhere in the same cycle must not swallow the hardware clear
      if (srenClr)
        cfg_r.single_rx_enable <= 1'b0;
    end
    else if (srenClr)
      cfg_r.single_rx_enable <= 1'b0;
  end

  // ==========================================
  // pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ckSync_r <= 3'h0;
      dtSync_r <= 3'h0;
      ckF_r <= 1'b0;
      dtF_r <= 1'b0;
    end
    else
    begin
      ckSync_r <= {ckSync_r[1:0], shiftClockIn};
      dtSync_r <= {dtSync_r[1:0], shiftDataIn};
      if (ckSync_r[1] == ckSync_r[2])
        ckF_r <= ckSync_r[2];
      if (dtSync_r[1] == dtSync_r[2])
        dtF_r <= dtSync_r[2];
    end
  end

  assign pinLvl = ckF_r ^ cfg_r.ckp;
  assign din = dtF_r ^ cfg_r.dtp;

  // ==========================================
  // baud generator; halted in sleep for master only
  assign divisor = cfg_r.wide ? {brgH_r, brgL_r} : {8'h00, brgL_r};
  assign busy = state_r != ssms_pkg::ST_IDLE;
  assign brgTick = busy && cfg_r.clock_source_select && !coreSleep && brgCnt_r == 16'h0000;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      brgCnt_r <= 16'h0000;
    else if (!busy || !cfg_r.clock_source_select || coreSleep || brgCnt_r == 16'h0000)
      brgCnt_r <= divisor;
    else
      brgCnt_r <= brgCnt_r - 16'h0001;
  end

  // master clock level, idle low before polarity
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sclk_r <= 1'b0;
    else if (!busy || !cfg_r.clock_source_select)
      sclk_r <= 1'b0;
    else if (brgTick)
      sclk_r <= ~sclk_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      pinLvlPrev_r <= 1'b0;
    else
      pinLvlPrev_r <= pinLvl;
  end

  // slave edges come from the pin, so sleep does not stop them
  assign fallEv = cfg_r.clock_source_select ? (brgTick && sclk_r) : (pinLvlPrev_r && !pinLvl);

  // ==========================================
  // transfer engine
  assign txLoad = txFull_r && !busy && cfg_r.transmit_enable && cfg_r.serial_port_enable;
  assign rxStart = cfg_r.serial_port_enable && (cfg_r.continuous_rx_enable || (cfg_r.single_rx_enable && cfg_r.clock_source_select));
  assign lastBit = (state_r == ssms_pkg::ST_TX ? cfg_r.tx9 : cfg_r.rx9)
    ? ssms_pkg::LAST9 : ssms_pkg::LAST8;
  assign rxWordEv = state_r == ssms_pkg::ST_RX && fallEv && bitCnt_r == lastBit;
  assign srenClr = rxWordEv && !cfg_r.continuous_rx_enable;

  always_comb
  begin
    rxWord = shift_r;
    rxWord[bitCnt_r] = din;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ssms_pkg::ST_IDLE;
      shift_r <= 9'h000;
      bitCnt_r <= 4'h0;
    end
    else
    begin
      unique case (state_r)
        ssms_pkg::ST_IDLE:
        begin
          bitCnt_r <= 4'h0;
          if (txLoad)
          begin
            state_r <= ssms_pkg::ST_TX;
            shift_r <= {cfg_r.tx_ninth_bit_value, txBuf_r};
          end
          else if (rxStart && !txFull_r)
          begin
            state_r <= ssms_pkg::ST_RX;
            shift_r <= 9'h000;
          end
        end
        ssms_pkg::ST_TX:
        begin
          if (fallEv)
          begin
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == lastBit)
              state_r <= ssms_pkg::ST_IDLE;
          end
        end
        ssms_pkg::ST_RX:
        begin
          if (!rxStart)
            state_r <= ssms_pkg::ST_IDLE;
          else if (fallEv)
          begin
            shift_r <= rxWord;
            bitCnt_r <= bitCnt_r + 4'h1;
            if (bitCnt_r == lastBit)
            begin
              bitCnt_r <= 4'h0;
              if (!cfg_r.continuous_rx_enable)
                state_r <= ssms_pkg::ST_IDLE;
            end
          end
        end
        default: state_r <= ssms_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // transmit holding buffer; a write clears the flag even against a move
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txBuf_r <= ssms_pkg::RST_BYTE;
      txFull_r <= 1'b0;
      txEmpty_r <= 1'b1;
    end
    else
    begin
      if (txWr)
        txBuf_r <= avs_writedata[7:0];
      txFull_r <= txWr | (txFull_r & ~txLoad);
      if (txWr)
        txEmpty_r <= 1'b0;
      else if (txLoad)
        txEmpty_r <= 1'b1;
    end
  end

  // ==========================================
  // receive buffer and flags; overrun keeps the unread word
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxBuf_r <= ssms_pkg::RST_BYTE;
      rx9d_r <= 1'b0;
      rxDone_r <= 1'b0;
      oerr_r <= 1'b0;
    end
    else
    begin
      if (rxWordEv && !(rxDone_r && !rxRd))
      begin
        rxBuf_r <= rxWord[7:0];
        rx9d_r <= cfg_r.rx9 & rxWord[8];
      end
      if (rxWordEv)
        rxDone_r <= 1'b1;
      else if (rxRd)
        rxDone_r <= 1'b0;
      if (!cfg_r.continuous_rx_enable)
        oerr_r <= 1'b0;
      else if (rxWordEv && rxDone_r && !rxRd)
        oerr_r <= 1'b1;
    end
  end

  // ==========================================
  // pin drivers and requests
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shiftClockOut <= 1'b0;
      shiftClockOe_n <= 1'b1;
      shiftDataOut <= 1'b0;
      shiftDataOe_n <= 1'b1;
      irqReq <= 1'b0;
      wakeCore <= 1'b0;
    end
    else
    begin
      shiftClockOut <= sclk_r ^ cfg_r.ckp;
      shiftClockOe_n <= !(cfg_r.clock_source_select && cfg_r.serial_port_enable);
      shiftDataOut <= (state_r == ssms_pkg::ST_TX && shift_r[bitCnt_r]) ^ cfg_r.dtp;
      shiftDataOe_n <= state_r != ssms_pkg::ST_TX;
      irqReq <= (rxDone_r && cfg_r.rxIe) || (txEmpty_r && cfg_r.txIe);
      wakeCore <= coreSleep && ((txEmpty_r && cfg_r.txIe) || (rxDone_r && cfg_r.rxIe));
    end
  end

  assign avs_readdata = rdData_r;
  assign avs_waitrequest = waitReq_r;

  // ==========================================
  // assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence seqIdleTwice;
    state_r == ssms_pkg::ST_IDLE ##1 state_r == ssms_pkg::ST_IDLE && $stable(cfg_r.ckp);
  endsequence

  sequence seqRxEntry;
    state_r != ssms_pkg::ST_RX ##1 state_r == ssms_pkg::ST_RX;
  endsequence

  AST_RX_ENTRY: assert property (seqRxEntry |-> $past(rxStart))
    else $error("reception started without an enable");
  AST_HALF_DUPLEX: assert property (state_r == ssms_pkg::ST_RX |=> shiftDataOe_n)
    else $error("data pin driven during reception");
  AST_SINGLE_STOP: assert property (srenClr |=> !cfg_r.single_rx_enable ##0 state_r == ssms_pkg::ST_IDLE)
    else $error("single reception did not stop");
  AST_WRITE_CLEARS: assert property (txWr |=> !txEmpty_r && txFull_r)
    else $error("write left empty flag set");
  AST_LOAD_SETS: assert property (txLoad && !txWr |=> txEmpty_r ##0 !txFull_r ##1 !shiftDataOe_n)
    else $error("move did not set empty flag or start sending");
  AST_SHIFT_REGISTER_EMPTY_BUSY: assert property (txLoad |=> rdMux[ssms_pkg::TX_SHIFT_REGISTER_EMPTY] == 1'b0
    || avs_address != ssms_pkg::ADDR_TXCTL)
    else $error("shifter empty bit set while sending");
  AST_IDLE_CLOCK: assert property (seqIdleTwice |=> shiftClockOut == $past(cfg_r.ckp))
    else $error("shift clock left idle level");
  AST_IRQ: assert property (rxDone_r && cfg_r.rxIe |=> irqReq)
    else $error("request missing for received word");
  AST_OERR_CLR: assert property ($fell(cfg_r.continuous_rx_enable) |-> ##[0:1] !oerr_r)
    else $error("error not cleared by disabling reception");
endmodule
`default_nettype wire

//--- testbench/ssms_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================
// serial peer on clock and data pins
module ssms_peer (
  input wire logic clkPin,
  input wire logic dataPin,
  input wire logic slaveMode,
  input wire logic idle,
  output logic peerClk,
  output logic peerData
);
  logic send[$];
  logic got[$];
  initial
  begin
    peerClk = 1'b0;
    peerData = 1'b1;
  end
  // master clock: sample on leading edge, data settles after trailing
  always @(clkPin)
  begin
    if (!slaveMode && clkPin !== idle)
      got.push_back(dataPin);
    if (!slaveMode && clkPin === idle && send.size() > 0)
    begin
      void'(send.pop_front());
      // released line shows the inverse, never the last bit
      peerData = send.size() > 0 ? send[0] : ~peerData;
    end
  end
  task automatic load(input logic [8:0] w, input int n);
    int i;
    for (i = 0; i < n; i++)
      send.push_back(w[i]);
    peerData = send[0];
  endtask
  // clock runs only inside a frame, idle low between frames
  task automatic frame(input int n);
    // keep pin changes off the sampling edge
    #10;
    repeat (n)
    begin
      #200 peerClk = 1'b1;
      #200 got.push_back(dataPin);
      peerClk = 1'b0;
    end
    #200;
  endtask
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic coreSleep = 1'b0;
  logic slave = 1'b0;
  logic ckp = 1'b0;
  logic clkOut, clkOe_n, datOut, datOe_n, irqReq, wakeCore, peerClk, peerData;
  logic clkPin, dataPin;
  logic clkPinD = 1'b0;
  logic [9:0] gapCnt = 10'h0;
  logic [9:0] lastGap = 10'h0;
  logic [8:0] w;
  logic [7:0] q;
  int failures = 0;
  int cmp_count = 0;
  assign clkPin = !clkOe_n ? clkOut : peerClk;
  assign dataPin = !datOe_n ? datOut : peerData;
  always #25 clk_sys = ~clk_sys;
  // ==========================
  // half-period meter on the clock pin
  always @(posedge clk_sys)
  begin
    clkPinD <= clkPin;
    if (clkPin !== clkPinD)
    begin
      lastGap <= gapCnt;
      gapCnt <= 10'h1;
    end
    else if (gapCnt != 10'h3ff)
      gapCnt <= gapCnt + 10'h1;
  end
  ssms_sync_serial dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .coreSleep(coreSleep),
    .shiftClockIn(clkPin), .shiftClockOut(clkOut), .shiftClockOe_n(clkOe_n),
    .shiftDataIn(dataPin), .shiftDataOut(datOut), .shiftDataOe_n(datOe_n),
    .irqReq(irqReq), .wakeCore(wakeCore)
  );
  ssms_peer peer (
    .clkPin(clkPin), .dataPin(dataPin), .slaveMode(slave), .idle(ckp),
    .peerClk(peerClk), .peerData(peerData)
  );
  // ==========================
  // bus and compare tasks
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n == 50)
    begin
      failures++;
      $display("[ERR] %0t bus answer timed out", $time);
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge keeps two requests from colliding in one step
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] exp, input logic [7:0] m);
    bus(1'b0, a, 8'h00);
    chk(q & m, exp);
  endtask
  task automatic waitbit(input logic [4:0] a, input int b);
    int n;
    n = 0;
    bus(1'b0, a, 8'h00);
    while (q[b] !== 1'b1 && n < 3000)
    begin
      bus(1'b0, a, 8'h00);
      n++;
    end
    if (n == 3000)
    begin
      failures++;
      $display("[ERR] %0t status bit never set", $time);
    end
  endtask
  task automatic getw(input int n);
    int i;
    w = 9'h0;
    for (i = 0; i < n; i++)
      w[i] = peer.got.size() > 0 ? peer.got.pop_front() : 1'bx;
  endtask
  // ==========================
  // scenarios
  task automatic t_reset;
    rdc(ssms_pkg::ADDR_TXCTL, 8'h02, 8'hff);
    rdc(ssms_pkg::ADDR_IRQ, 8'h02, 8'hff);
    rdc(5'h1e, 8'h00, 8'hff);
    wr(ssms_pkg::ADDR_TXCTL, 8'h00);
    rdc(ssms_pkg::ADDR_TXCTL, 8'h02, 8'h02);
    chk(clkOe_n, 1'b1);
    $display("t_reset done");
  endtask
  task automatic t_tx2;
    wr(ssms_pkg::ADDR_BRGL, 8'h01);
    wr(ssms_pkg::ADDR_RXCTL, 8'h80);
    wr(ssms_pkg::ADDR_TXCTL, 8'ha0);
    peer.got.delete();
    wr(ssms_pkg::ADDR_TXBUF, 8'ha5);
    rdc(ssms_pkg::ADDR_IRQ, 8'h02, 8'h02);
    wr(ssms_pkg::ADDR_TXBUF, 8'h3c);
    rdc(ssms_pkg::ADDR_IRQ, 8'h00, 8'h02);
    waitbit(ssms_pkg::ADDR_IRQ, 1);
    waitbit(ssms_pkg::ADDR_TXCTL, 1);
    getw(8);
    chk(w, 9'h0a5);
    getw(8);
    chk(w, 9'h03c);
    chk(lastGap, 10'd2);
    chk(clkPin, 1'b0);
    $display("t_tx2 done");
  endtask
  task automatic t_tx9;
    wr(ssms_pkg::ADDR_BAUD, 8'h38);
    ckp <= 1'b1;
    wr(ssms_pkg::ADDR_BRGH, 8'h01);
    wr(ssms_pkg::ADDR_BRGL, 8'h00);
    chk(clkPin, 1'b1);
    wr(ssms_pkg::ADDR_TXCTL, 8'he1);
    peer.got.delete();
    wr(ssms_pkg::ADDR_TXBUF, 8'h96);
    waitbit(ssms_pkg::ADDR_TXCTL, 1);
    getw(9);
    chk(w, 9'h069);
    chk(lastGap, 10'd257);
    wr(ssms_pkg::ADDR_BAUD, 8'h00);
    ckp <= 1'b0;
    // receive needs a half period longer than the data synchroniser delay
    wr(ssms_pkg::ADDR_BRGL, 8'h04);
    $display("t_tx9 done");
  endtask
  task automatic t_srx;
    wr(ssms_pkg::ADDR_TXCTL, 8'h80);
    wr(ssms_pkg::ADDR_IRQ, 8'h04);
    peer.load(9'h05a, 8);
    wr(ssms_pkg::ADDR_RXCTL, 8'ha0);
    waitbit(ssms_pkg::ADDR_IRQ, 0);
    chk(irqReq, 1'b1);
    rdc(ssms_pkg::ADDR_RXBUF, 8'h5a, 8'hff);
    rdc(ssms_pkg::ADDR_RXCTL, 8'h80, 8'hff);
    chk(irqReq, 1'b0);
    repeat (20) @(posedge clk_sys);
    chk(gapCnt > 10'd16, 1'b1);
    $display("t_srx done");
  endtask
  task automatic t_crx;
    wr(ssms_pkg::ADDR_IRQ, 8'h00);
    peer.got.delete();
    peer.load(9'h1a5, 9);
    peer.load(9'h0c3, 9);
    wr(ssms_pkg::ADDR_RXCTL, 8'hf0);
    waitbit(ssms_pkg::ADDR_IRQ, 0);
    rdc(ssms_pkg::ADDR_RXCTL, 8'h01, 8'h01);
    waitbit(ssms_pkg::ADDR_RXCTL, 1);
    rdc(ssms_pkg::ADDR_RXCTL, 8'hd2, 8'hd2);
    rdc(ssms_pkg::ADDR_RXBUF, 8'ha5, 8'hff);
    chk(peer.got.size() >= 18, 1'b1);
    wr(ssms_pkg::ADDR_RXCTL, 8'hc0);
    rdc(ssms_pkg::ADDR_RXCTL, 8'h00, 8'h12);
    $display("t_crx done");
  endtask
  task automatic t_slave;
    wr(ssms_pkg::ADDR_RXCTL, 8'h80);
    wr(ssms_pkg::ADDR_TXCTL, 8'h20);
    wr(ssms_pkg::ADDR_IRQ, 8'h08);
    slave <= 1'b1;
    peer.got.delete();
    wr(ssms_pkg::ADDR_TXBUF, 8'h81);
    wr(ssms_pkg::ADDR_TXBUF, 8'h7e);
    coreSleep <= 1'b1;
    @(posedge clk_sys);
    chk(clkOe_n, 1'b1);
    chk(wakeCore, 1'b0);
    peer.frame(8);
    repeat (10) @(posedge clk_sys);
    chk(wakeCore, 1'b1);
    peer.frame(8);
    repeat (10) @(posedge clk_sys);
    getw(8);
    chk(w, 9'h081);
    getw(8);
    chk(w, 9'h07e);
    coreSleep <= 1'b0;
    slave <= 1'b0;
    $display("t_slave done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset;
    t_tx2;
    t_tx9;
    t_srx;
    t_crx;
    t_slave;
    end_sim;
  end
  // run needs well under a millisecond
  initial
  begin
    #2000000;
    failures++;
    end_sim;
  end
endmodule
`default_nettype wire
